// *** bench/cpi_source.sv ***
`timescale 1ns/1ps
module cpi_source (
  input  wire logic        run_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic        dev_clk_i,
  input  wire logic [16:0] addr_i,
  output logic             clk_o,
  output logic [7:0]       data_o
);
  logic [15:0] n_q = 16'h0000;
  logic [7:0]  b;
  wire logic   own = !(mode_i inside {3'h4, 3'h5});
  wire logic   ser = mode_i inside {3'h3, 3'h4};
  wire logic   ck  = own ? clk_o : dev_clk_i;
  initial clk_o = 1'b0;
  always #80 clk_o = run_i && own ? !clk_o : 1'b0;
  always @(negedge ck or negedge run_i) n_q <= run_i ? n_q + 16'h1 : 16'h0;
  always_comb begin
    b = ser ? n_q[10:3] : n_q[7:0];
    if (mode_i inside {3'h1, 3'h2, 3'h5}) b = addr_i[7:0];
    b = b * 8'h1D + 8'h33;
    // unused upper lines keep moving so a stray use shows
    data_o = ser ? {n_q[6:0], b[n_q[2:0]]} : b;
  end
endmodule

// *** bench/cpi_top_monitor.sv ***
`timescale 1ns/1ps
module cpi_top_monitor #(
  parameter int unsigned ADDR_W = 17,
  parameter int unsigned UIO_W  = 26
) (
  input wire logic             mclk_i,
  input wire logic             reset_i,
  input wire logic             config_in_progress_n_i,
  input wire logic             config_in_progress_n_o,
  input wire logic             config_in_progress_n_oe_o,
  input wire logic             config_select_n_i,
  input wire logic [2:0]       config_mode_select_i,
  input wire logic             config_clock_oe_o,
  input wire logic [UIO_W-1:0] pin_oe_o,
  input wire logic [UIO_W-1:0] user_oe_i,
  input wire logic             config_byte_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [6:0] up_q;
  wire logic  cfg = !config_in_progress_n_i && !config_select_n_i;
  wire logic  am  = config_mode_select_i inside {3'h1, 3'h2, 3'h5};
  wire logic  om  = config_mode_select_i inside {3'h4, 3'h5};
  // saturating age since reset, for the init window
  always_ff @(posedge mclk_i) begin
    if (reset_i) up_q <= 7'h00;
    else if (up_q != 7'h7F) up_q <= up_q + 7'h01;
  end
  init_hold_a:
    assert property (up_q < 7'h3E |-> config_in_progress_n_oe_o)
    else $error("progress line released early");
  init_done_a:
    assert property (up_q > 7'h44 |-> !config_in_progress_n_oe_o)
    else $error("progress line held after init");
  open_col_a:
    assert property (config_in_progress_n_oe_o |-> !config_in_progress_n_o)
    else $error("progress line driven high");
  user_io_a:
    assert property ((config_in_progress_n_i && $stable(user_oe_i))[*6]
      |-> pin_oe_o == user_oe_i) else $error("user enables not passed");
  data_in_a:
    assert property ((!config_in_progress_n_i)[*6]
      |-> pin_oe_o[7:0] == 8'h00) else $error("data pins driven");
  addr_on_a:
    assert property ((cfg && am)[*6] |-> &pin_oe_o[24:8])
    else $error("address pins not driven");
  addr_off_a:
    assert property ((!config_in_progress_n_i && !(cfg && am))[*6]
      |-> pin_oe_o[24:8] == 17'h0) else $error("address pins driven");
  config_clock_dir_a:
    assert property (cfg[*6] |-> config_clock_oe_o == om)
    else $error("config clock direction wrong");
  no_cfg_a:
    assert property ((!cfg)[*5] |-> !config_byte_valid_o)
    else $error("byte taken while not selected");
  cover property (cfg && am && config_byte_valid_o);
  cover property (cfg && om && config_byte_valid_o);
  cover property ($fell(config_in_progress_n_oe_o));
endmodule
bind cpi_top cpi_top_monitor #(.ADDR_W(ADDR_W), .UIO_W(UIO_W)) mon (
  .mclk_i, .reset_i, .config_in_progress_n_i, .config_in_progress_n_o,
  .config_in_progress_n_oe_o, .config_select_n_i, .config_mode_select_i,
  .config_clock_oe_o, .pin_oe_o, .user_oe_i, .config_byte_valid_o);

// *** bench/cpi_top_tb.sv ***
`timescale 1ns/1ps
module cpi_top_tb;
  logic        mclk_i = 0, reset_i = 1, uclk = 0, urst_n = 1;
  logic        pull = 0, run = 0, sel_n = 1, cv, con_oe, con_o, cc_o, cc_oe;
  logic [2:0]  mode = 3'h0;
  logic [25:0] ext = 26'h2A5_5A5A, uout = 26'h155_AAAA, uoe = 26'h0FF_00FF;
  logic [25:0] p_o, p_oe, p_i, u_in;
  logic [7:0]  cb, sd;
  logic        sc;
  int          n_mismatch = 0, tests_run = 0;
  wire  logic  line = !(con_oe || pull);
  assign p_i = (p_oe & p_o) | (~p_oe & (run ? {ext[25:8], sd} : ext));
  cpi_top DUT (.mclk_i, .reset_i, .user_clock_i(uclk), .user_reset_n_i(urst_n),
    .config_in_progress_n_i(line), .config_in_progress_n_o(con_o),
    .config_in_progress_n_oe_o(con_oe), .config_select_n_i(sel_n),
    .config_mode_select_i(mode), .config_clock_i(sc), .config_clock_o(cc_o),
    .config_clock_oe_o(cc_oe), .pin_i(p_i), .pin_o(p_o), .pin_oe_o(p_oe),
    .user_out_i(uout), .user_oe_i(uoe), .user_in_o(u_in),
    .config_byte_o(cb), .config_byte_valid_o(cv));
  cpi_source src (.run_i(run), .mode_i(mode), .dev_clk_i(cc_o),
    .addr_i(p_o[24:8]), .clk_o(sc), .data_o(sd));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] f(input int i);
    return 8'(i) * 8'h1D + 8'h33;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_user;
    repeat (4) @(negedge mclk_i);
    chk("pin_oe", p_oe, uoe);
    chk("pin_o", p_o, 0);
    // second user edge sees the pins the first edge drove
    repeat (2) begin
      uclk = 1;
      repeat (5) @(negedge mclk_i);
      uclk = 0;
      repeat (5) @(negedge mclk_i);
    end
    chk("pin_o", p_o, uout);
    chk("user_in", u_in, (uoe & uout) | (~uoe & ext));
    urst_n = 0;
    repeat (5) @(negedge mclk_i);
    chk("user_in", u_in, 0);
    chk("pin_o", p_o, 0);
    urst_n = 1;
    $display("user io done");
  endtask
  task automatic t_cfg(input logic [2:0] m, input int nb);
    int   w;
    logic ep;
    ep = m inside {3'h1, 3'h2, 3'h5};
    mode = m;
    sel_n = 0;
    pull = 1;
    repeat (4) @(negedge mclk_i);
    run = 1;
    chk("a_oe", p_oe[24:8], ep ? 17'h1FFFF : 17'h0);
    chk("c_oe", cc_oe, m inside {3'h4, 3'h5});
    if (ep) chk("addr", p_o[24:8], 0);
    for (int i = 0; i < nb; i++) begin
      w = 0;
      while (cv !== 1'b1 && w < 2000) begin
        @(negedge mclk_i);
        w++;
      end
      chk("wait", w < 2000, 1);
      chk("byte", cb, f(i));
      repeat (2) @(negedge mclk_i);
      if (ep) chk("addr", p_o[24:8], i + 1);
    end
    run = 0;
    pull = 0;
    sel_n = 1;
    repeat (8) @(negedge mclk_i);
    $display("mode %0d done", m);
  endtask
  task automatic t_sel;
    int seen = 0;
    mode = 3'h6;
    pull = 1;
    repeat (4) @(negedge mclk_i);
    run = 1;
    // user clock edge taken while the line is low
    uclk = 1;
    repeat (200) begin
      @(negedge mclk_i);
      if (cv !== 1'b0) seen++;
    end
    uclk = 0;
    chk("ignored", seen, 0);
    chk("pins", p_oe, 0);
    run = 0;
    pull = 0;
    repeat (8) @(negedge mclk_i);
    chk("pin_o", p_o, uout);
    $display("select done");
  endtask
  initial begin
    repeat (2) @(negedge mclk_i);
    reset_i = 0;
    chk("con_oe", con_oe, 1);
    repeat (70) @(negedge mclk_i);
    chk("con_oe", con_oe, 0);
    $display("init done");
    t_user();
    for (int m = 1; m <= 6; m++) t_cfg(3'(m), 3);
    t_sel();
    finish_test();
  end
  // far above the few thousand cycles the tests need
  initial begin
    #500_000;
    n_mismatch++;
    finish_test();
  end
endmodule

// *** verilog/cpi_pkg.sv ***
package cpi_pkg;
  localparam int unsigned MCLK_HZ      = 50_000_000;
  // generated configuration clock, about 1 MHz
  localparam int unsigned CONFIG_CLOCK_OUT_HZ  = 1_000_000;
  localparam int unsigned CONFIG_CLOCK_HALF    = MCLK_HZ / (2 * CONFIG_CLOCK_OUT_HZ);
  localparam int unsigned ADDR_W       = 17;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned UIO_W        = 26;
  localparam int unsigned MODE_W       = 3;
  // power-up initialisation length, mclk cycles
  localparam int unsigned INIT_CYCLES  = 64;
  localparam logic [2:0] MODE_PAR_EP1  = 3'h1;
  localparam logic [2:0] MODE_PAR_EP2  = 3'h2;
  localparam logic [2:0] MODE_SER_IN   = 3'h3;
  localparam logic [2:0] MODE_SER_OUT  = 3'h4;
  localparam logic [2:0] MODE_PAR_EP5  = 3'h5;
  localparam logic [2:0] MODE_PAR_IN   = 3'h6;
  // user pin index of data bit 0; upper data follow, then address
  localparam int unsigned PIN_D0       = 0;
  localparam int unsigned PIN_A0       = 8;
endpackage

// *** verilog/cpi_sync.sv ***
`timescale 1ns/1ps
module cpi_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** verilog/cpi_top.sv ***
`timescale 1ns/1ps
module cpi_top #(
  parameter int unsigned ADDR_W = cpi_pkg::ADDR_W,
  parameter int unsigned UIO_W  = cpi_pkg::UIO_W
) (
  input  wire logic                       mclk_i,
  input  wire logic                       reset_i,
  input  wire logic                       user_clock_i,
  input  wire logic                       user_reset_n_i,
  input  wire logic                       config_in_progress_n_i,
  output logic                            config_in_progress_n_o,
  output logic                            config_in_progress_n_oe_o,
  input  wire logic                       config_select_n_i,
  input  wire logic [cpi_pkg::MODE_W-1:0] config_mode_select_i,
  input  wire logic                       config_clock_i,
  output logic                            config_clock_o,
  output logic                            config_clock_oe_o,
  input  wire logic [UIO_W-1:0]           pin_i,
  output logic      [UIO_W-1:0]           pin_o,
  output logic      [UIO_W-1:0]           pin_oe_o,
  input  wire logic [UIO_W-1:0]           user_out_i,
  input  wire logic [UIO_W-1:0]           user_oe_i,
  output logic      [UIO_W-1:0]           user_in_o,
  output logic [cpi_pkg::DATA_W-1:0]      config_byte_o,
  output logic                            config_byte_valid_o
);
  localparam int unsigned DW = cpi_pkg::DATA_W;
  localparam int unsigned CW = $clog2(cpi_pkg::CONFIG_CLOCK_HALF + 1);
  localparam int unsigned IW = $clog2(cpi_pkg::INIT_CYCLES + 1);

  typedef enum logic [2:0] {
    CPI_INIT   = 3'h1,
    CPI_USER   = 3'h2,
    CPI_CONFIG = 3'h4
  } cpi_state_t;

  logic                    con_s, sel_n_s, config_clock_s, config_clock_sd_q;
  logic [cpi_pkg::MODE_W-1:0] mode_s;
  logic [UIO_W-1:0]        pin_s;
  logic [UIO_W-1:0]        user_q;
  logic                    uclk_s, uclk_d_q, ures_n_s;
  cpi_state_t              state_q;
  logic [IW-1:0]           init_cnt_q;
  logic [CW-1:0]           div_cnt_q;
  logic                    config_clock_gen_q;
  logic [ADDR_W-1:0]       addr_q;
  logic [DW-1:0]           shift_q;
  logic [$clog2(DW)-1:0]   bit_cnt_q;
  logic                    dev_clk_mode, eprom_mode, par_mode, cfg_act;
  logic                    config_clock_rise, gen_rise;
  logic [DW-1:0]           data_in;
  logic                    uclk_rise_w;

  cpi_sync #(.W(UIO_W + cpi_pkg::MODE_W + 5)) u_sync (
    .mclk_i (mclk_i),
    .reset_i(reset_i),
    .async_i({pin_i, config_mode_select_i, config_in_progress_n_i,
              config_select_n_i, config_clock_i, user_clock_i,
              user_reset_n_i}),
    .sync_o ({pin_s, mode_s, con_s, sel_n_s, config_clock_s, uclk_s, ures_n_s})
  );

  assign dev_clk_mode = (mode_s == cpi_pkg::MODE_SER_OUT) ||
                        (mode_s == cpi_pkg::MODE_PAR_EP5);
  assign eprom_mode   = (mode_s == cpi_pkg::MODE_PAR_EP1) ||
                        (mode_s == cpi_pkg::MODE_PAR_EP2) ||
                        (mode_s == cpi_pkg::MODE_PAR_EP5);
  assign par_mode     = eprom_mode || (mode_s == cpi_pkg::MODE_PAR_IN);
  assign cfg_act      = (state_q == CPI_CONFIG) && !sel_n_s;
  assign gen_rise     = (div_cnt_q == CW'(cpi_pkg::CONFIG_CLOCK_HALF - 1)) &&
                        !config_clock_gen_q;
  assign config_clock_rise    = dev_clk_mode ? gen_rise : (config_clock_s && !config_clock_sd_q);
  assign data_in      = pin_s[cpi_pkg::PIN_D0 +: DW];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q    <= CPI_INIT;
      init_cnt_q <= '0;
    end else begin
      case (state_q)
        CPI_INIT: begin
          if (init_cnt_q == IW'(cpi_pkg::INIT_CYCLES - 1)) begin
            state_q <= CPI_USER;
          end
          init_cnt_q <= init_cnt_q + 1'b1;
        end
        CPI_USER: if (!con_s) begin
          state_q <= CPI_CONFIG;
        end
        CPI_CONFIG: if (con_s) begin
          state_q <= CPI_USER;
        end
        default: state_q <= CPI_INIT;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      config_in_progress_n_o    <= 1'b0;
      config_in_progress_n_oe_o <= 1'b1;
    end else begin
      config_in_progress_n_o    <= 1'b0;
      // open collector: only ever pull low
      config_in_progress_n_oe_o <= (state_q == CPI_INIT);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !cfg_act || !dev_clk_mode) begin
      div_cnt_q  <= '0;
      config_clock_gen_q <= 1'b0;
    end else if (div_cnt_q == CW'(cpi_pkg::CONFIG_CLOCK_HALF - 1)) begin
      div_cnt_q  <= '0;
      config_clock_gen_q <= !config_clock_gen_q;
    end else begin
      div_cnt_q  <= div_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      config_clock_sd_q         <= 1'b0;
      config_clock_o    <= 1'b0;
      config_clock_oe_o <= 1'b0;
    end else begin
      config_clock_sd_q         <= config_clock_s;
      config_clock_o    <= config_clock_gen_q;
      config_clock_oe_o <= cfg_act && dev_clk_mode;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !cfg_act) begin
      shift_q             <= '0;
      bit_cnt_q           <= '0;
      config_byte_o       <= '0;
      config_byte_valid_o <= 1'b0;
    end else begin
      config_byte_valid_o <= 1'b0;
      if (config_clock_rise) begin
        if (par_mode) begin
          config_byte_o       <= data_in;
          config_byte_valid_o <= 1'b1;
        end else begin
          // serial from data0, first bit lsb
          shift_q   <= {data_in[0], shift_q[DW-1:1]};
          bit_cnt_q <= bit_cnt_q + 1'b1;
          if (bit_cnt_q == ($clog2(DW))'(DW - 1)) begin
            config_byte_o       <= {data_in[0], shift_q[DW-1:1]};
            config_byte_valid_o <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !cfg_act) begin
      addr_q <= '0;
    end else if (config_clock_rise && eprom_mode) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else if (cfg_act) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
      if (eprom_mode) begin
        pin_o[cpi_pkg::PIN_A0 +: ADDR_W]    <= addr_q;
        pin_oe_o[cpi_pkg::PIN_A0 +: ADDR_W] <= '1;
      end
    end else if (state_q == CPI_USER) begin
      pin_o    <= user_q;
      pin_oe_o <= user_oe_i;
    end else begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end
  end

  // user array registers
  // user clock edge found on the synced copy, never used as a clock
  assign uclk_rise_w = uclk_s && !uclk_d_q;
  always_ff @(posedge mclk_i) begin
    if (reset_i || !ures_n_s) begin
      uclk_d_q  <= 1'b0;
      user_q    <= '0;
      user_in_o <= '0;
    end else begin
      uclk_d_q <= uclk_s;
      if (uclk_rise_w) begin
        user_q    <= user_out_i;
        user_in_o <= pin_s;
      end
    end
  end
endmodule
